// ===== daqc_pkg.sv
// Package for the acquisition control block: offsets, fields, reset values, timing.
// Assumes a 32-bit register port and a 25 MHz core clock.
package daqc_pkg;

    localparam logic [5:0]  DAQC_OFS_CNT0    = 6'h00;
    localparam logic [5:0]  DAQC_OFS_CNT1    = 6'h04;
    localparam logic [5:0]  DAQC_OFS_CNT2    = 6'h08;
    localparam logic [5:0]  DAQC_OFS_TCTRL   = 6'h0C;
    localparam logic [5:0]  DAQC_OFS_ADDATA  = 6'h10;
    localparam logic [5:0]  DAQC_OFS_CTLSTAT = 6'h18;
    localparam logic [5:0]  DAQC_OFS_DIO     = 6'h1C;
    localparam logic [5:0]  DAQC_OFS_SWTRIG  = 6'h20;

    localparam int          DAQC_BIT_DMA     = 0;
    localparam int          DAQC_BIT_IRQ     = 1;
    localparam int          DAQC_BIT_PACER   = 2;
    localparam int          DAQC_BIT_EXT     = 3;
    localparam int          DAQC_BIT_SCAN    = 4;
    localparam int          DAQC_CH_LSB      = 5;
    localparam int          DAQC_RNG_LSB     = 9;
    localparam int          DAQC_STAT_READY  = 0;
    localparam int          DAQC_STAT_OVR    = 1;

    localparam logic [12:0] DAQC_CTRL_RST    = 13'h0000;

    // Conversion time figure and its cycle count at the core clock.
    localparam int          DAQC_CONV_NS     = 8000;
    localparam int          DAQC_CLK_NS      = 40;
    localparam int          DAQC_CONV_CYC    = DAQC_CONV_NS / DAQC_CLK_NS;

    typedef struct packed {
        logic [3:0] range;
        logic [3:0] chan;
        logic       scan;
        logic       ext;
        logic       pacer;
        logic       irq;
        logic       dma;
    } daqc_ctrl_t;

    typedef struct packed {
        logic        sel;
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [31:0] wdata;
    } daqc_bus_t;

endpackage : daqc_pkg

// ===== daqc_top.sv
// Acquisition control: control word, scan sequencer, status flags, digital I/O, timer decode.
// Assumes a synchronous register port on CORE_CLK_I, one access per strobe cycle.
// Summary of operation
// RL1: Scan off converts only selected channel.
// RL2: Scan on steps down to zero, then restarts.
// RL3: Channel field is control bits eight to five.
// RL4: Host keeps channels within input mode limit.
// RL5: Range codes select the bipolar ranges.
// RL6: Range codes select the unipolar ranges.
// RL7: Status bit zero shows conversion complete.
// RL8: Overrun flag raised only in bus-master mode.
// RL9: In software mode, a trigger-register write while idle starts one conversion.
// RL10: Digital port read returns sixteen inputs.
// RL11: Digital port write updates all outputs.
// RL12: Timer counters and control byte decoded.
// RL13: Cascaded counters pace; third counter is free.
// RL14: Control low bits select trigger and transfer.
// RL15: Result word holds channel and twelve bits.
// RL16: External rising edge starts conversion.
// RL17: Reading result or converting clears ready.
// RL18: Sequencer advances per trigger, reloads on write.
// RL19: Reset clears control word and status flags.
`timescale 1ns/100ps
module daqc_top
    import daqc_pkg::*;
(
    input  wire logic                  CORE_CLK_I,    // Core clock.
    input  wire logic                  RST_N_I,       // Async reset, active low.
    input  wire daqc_pkg::daqc_bus_t   BUS_I,         // Register access strobes.
    output logic        [31:0]         RDATA_O,       // Read data.
    output logic                       TMR_SEL_O,     // Timer chip select.
    output logic        [1:0]          TMR_ADDR_O,    // Timer register index.
    output logic                       TMR_CTRL_WR_O, // Timer control byte write.
    input  wire logic   [31:0]         TMR_RDATA_I,   // Timer read data.
    input  wire logic                  PACER_OUT_I,   // Cascaded counter output pin.
    input  wire logic                  EXT_TRIG_I,    // External trigger pin.
    input  wire logic   [15:0]         DIN_I,         // Digital input pins.
    output logic        [15:0]         DOUT_O,        // Digital output lines.
    output logic        [3:0]          MUX_SEL_O,     // Multiplexer channel.
    output logic        [3:0]          RANGE_O,       // Range code.
    output logic                       RANGE_UNI_O,   // High for a unipolar range.
    output logic                       CONV_START_O,  // Converter start pulse.
    input  wire logic                  CONV_DONE_I,   // Converter done pulse.
    input  wire logic   [11:0]         CONV_DATA_I,   // Converter result.
    input  wire logic                  DMA_FULL_I,    // Bus-master queue full.
    output logic                       IRQ_EN_O,      // Interrupt transfer enable.
    output logic                       DMA_EN_O       // Bus-master transfer enable.
);
    import daqc_pkg::*;

    typedef enum logic [1:0] {
        DAQC_IDLE = 2'b01,
        DAQC_CONV = 2'b10
    } daqc_state_t;

    daqc_ctrl_t  ctrl_q;
    daqc_state_t state_q;
    logic [3:0]  scan_ch_q;
    logic [3:0]  conv_ch_q;
    logic [15:0] result_q;
    logic        ready_q;
    logic        ovr_q;
    logic        unread_q;
    logic [15:0] dout_q;
    logic [2:0]  ext_sync_q;
    logic [2:0]  pace_sync_q;
    logic [15:0] din_s1_q;
    logic [15:0] din_s2_q;
    logic [7:0]  conv_cnt_q;
    logic        ctrl_wr;
    logic        data_rd;
    logic        trig;

    function automatic logic hit(input daqc_bus_t b, input logic [5:0] ofs);
        hit = b.sel && (b.addr == ofs);
    endfunction : hit

    assign ctrl_wr = BUS_I.wr && hit(BUS_I, DAQC_OFS_CTLSTAT);
    assign data_rd = BUS_I.rd && hit(BUS_I, DAQC_OFS_ADDATA);

    // Input pins pass two flip-flops before edge detection.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ext_sync_q  <= 3'h0;
            pace_sync_q <= 3'h0;
            din_s1_q    <= 16'h0000;
            din_s2_q    <= 16'h0000;
        end
        else
        begin
            ext_sync_q  <= {ext_sync_q[1:0], EXT_TRIG_I};
            pace_sync_q <= {pace_sync_q[1:0], PACER_OUT_I};
            din_s1_q    <= DIN_I;
            din_s2_q    <= din_s1_q;
        end
    end

    // Only one source is live; external mode masks both internal ones.
    always_comb
    begin
        if (ctrl_q.ext)
            trig = ext_sync_q[1] && !ext_sync_q[2];                          // [RL16] [RL14]
        else if (ctrl_q.pacer)
            trig = pace_sync_q[1] && !pace_sync_q[2];                        // [RL13] [RL14]
        else
            trig = BUS_I.wr && hit(BUS_I, DAQC_OFS_SWTRIG);                  // [RL9]
    end

    // Control register.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            ctrl_q <= DAQC_CTRL_RST;                                         // [RL19]
        else if (ctrl_wr)
            ctrl_q <= BUS_I.wdata[12:0];                                     // [RL3] [RL14]
    end

    // Scan sequencer; a trigger during a conversion is dropped.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            scan_ch_q <= 4'h0;
        else if (ctrl_wr)
            scan_ch_q <= BUS_I.wdata[DAQC_CH_LSB +: 4];                      // [RL18]
        else if (trig && state_q == DAQC_IDLE)
        begin
            if (!ctrl_q.scan)
                scan_ch_q <= ctrl_q.chan;                                    // [RL1]
            else if (scan_ch_q == 4'h0)
                scan_ch_q <= ctrl_q.chan;                                    // [RL2]
            else
                scan_ch_q <= scan_ch_q - 4'h1;                               // [RL2] [RL18]
        end
    end

    // Conversion sequencer: waits for the converter, with a timeout.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state_q    <= DAQC_IDLE;
            conv_cnt_q <= 8'h00;
            conv_ch_q  <= 4'h0;
        end
        else
        begin
            case (state_q)
                DAQC_IDLE:
                begin
                    conv_cnt_q <= 8'h00;
                    if (trig)
                    begin
                        state_q   <= DAQC_CONV;
                        conv_ch_q <= ctrl_q.scan ? scan_ch_q : ctrl_q.chan;  // [RL1]
                    end
                end
                DAQC_CONV:
                begin
                    conv_cnt_q <= conv_cnt_q + 8'h01;
                    if (CONV_DONE_I || conv_cnt_q == 8'(DAQC_CONV_CYC))
                        state_q <= DAQC_IDLE;
                end
                default:
                    state_q <= DAQC_IDLE;
            endcase
        end
    end

    // Result and status flags; completion wins over a simultaneous read or clear.
    // Ready drops at every accepted trigger, so it cannot tell whether the last
    // result was taken; a separate unread flag tracks that for the overrun.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            result_q <= 16'h0000;
            ready_q  <= 1'b0;                                                // [RL19]
            unread_q <= 1'b0;
            ovr_q    <= 1'b0;                                                // [RL19]
        end
        else
        begin
            if (data_rd)
                unread_q <= 1'b0;
            if (ctrl_wr && !BUS_I.wdata[DAQC_BIT_DMA])
                ovr_q <= 1'b0;
            if (state_q == DAQC_CONV && CONV_DONE_I)
            begin
                result_q <= {CONV_DATA_I, conv_ch_q};                        // [RL15]
                ready_q  <= 1'b1;                                            // [RL7]
                unread_q <= 1'b1;
                if (unread_q && ctrl_q.dma && DMA_FULL_I && !data_rd)
                    ovr_q <= 1'b1;                                           // [RL8]
            end
            else if (state_q == DAQC_IDLE && trig)
                ready_q <= 1'b0;                                             // [RL17]
            else if (data_rd)
                ready_q <= 1'b0;                                             // [RL17]
        end
    end

    // Digital output latch.
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            dout_q <= 16'h0000;
        else if (BUS_I.wr && hit(BUS_I, DAQC_OFS_DIO))
            dout_q <= BUS_I.wdata[15:0];                                     // [RL11]
    end

    // Read multiplexer.
    always_comb
    begin
        RDATA_O = 32'h0000_0000;
        if (BUS_I.sel)
        begin
            case (BUS_I.addr)
                DAQC_OFS_CNT0, DAQC_OFS_CNT1, DAQC_OFS_CNT2:
                    RDATA_O = TMR_RDATA_I;                                   // [RL12]
                DAQC_OFS_ADDATA:
                    RDATA_O = {16'h0000, result_q};                          // [RL15]
                DAQC_OFS_CTLSTAT:
                    RDATA_O = {30'h0, ovr_q, ready_q};                       // [RL7] [RL8]
                DAQC_OFS_DIO:
                    RDATA_O = {16'h0000, din_s2_q};                          // [RL10] [RL11]
                default:
                    RDATA_O = 32'h0000_0000;
            endcase
        end
    end

    assign TMR_SEL_O     = BUS_I.sel && (BUS_I.addr[5:4] == 2'h0);           // [RL12]
    assign TMR_ADDR_O    = BUS_I.addr[3:2];
    assign TMR_CTRL_WR_O = BUS_I.wr && hit(BUS_I, DAQC_OFS_TCTRL);           // [RL12]
    assign DOUT_O        = dout_q;
    assign MUX_SEL_O     = ctrl_q.scan ? scan_ch_q : ctrl_q.chan;            // [RL1] [RL2]
    assign RANGE_O       = ctrl_q.range;                                     // [RL5] [RL6]
    assign RANGE_UNI_O   = ctrl_q.range[2];                                  // [RL6]
    assign CONV_START_O  = trig && (state_q == DAQC_IDLE);                   // [RL9]
    assign IRQ_EN_O      = ctrl_q.irq;                                       // [RL14]
    assign DMA_EN_O      = ctrl_q.dma;                                       // [RL14]

    sequence s_sw_req;
        !ctrl_q.ext && !ctrl_q.pacer && BUS_I.wr && hit(BUS_I, DAQC_OFS_SWTRIG)
        && state_q == DAQC_IDLE;
    endsequence

    sequence s_conv_begin;
        CONV_START_O ##1 state_q == DAQC_CONV;
    endsequence

    property p_sw_start;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        s_sw_req |-> s_conv_begin;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("Soft trigger lost"); // [RL9]

    property p_ready_set;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (state_q == DAQC_CONV && CONV_DONE_I) |=> ready_q && result_q[3:0] == $past(conv_ch_q);
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("Ready not set"); // [RL7] [RL15]

    property p_ready_clr;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (data_rd && !(state_q == DAQC_CONV && CONV_DONE_I)) |=> !ready_q;
    endproperty
    a_ready_clr: assert property (p_ready_clr) else $error("Ready not cleared"); // [RL17]

    property p_ovr_dma;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $rose(ovr_q) |-> $past(ctrl_q.dma);
    endproperty
    a_ovr_dma: assert property (p_ovr_dma) else $error("Overrun outside DMA"); // [RL8]

    property p_ovr_set;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (state_q == DAQC_CONV && CONV_DONE_I && unread_q && ctrl_q.dma
         && DMA_FULL_I && !data_rd) |=> ovr_q;
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("Overrun not raised"); // [RL8]

    property p_scan_wrap;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (ctrl_q.scan && !ctrl_wr && trig && state_q == DAQC_IDLE && scan_ch_q == 4'h0)
        |=> scan_ch_q == $past(ctrl_q.chan);
    endproperty
    a_scan_wrap: assert property (p_scan_wrap) else $error("Scan no wrap"); // [RL2]

    property p_scan_step;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (ctrl_q.scan && !ctrl_wr && trig && state_q == DAQC_IDLE && scan_ch_q != 4'h0)
        |=> scan_ch_q == $past(scan_ch_q) - 4'h1;
    endproperty
    a_scan_step: assert property (p_scan_step) else $error("Scan no step"); // [RL2] [RL18]

    property p_single;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !ctrl_q.scan |-> MUX_SEL_O == ctrl_q.chan;
    endproperty
    a_single: assert property (p_single) else $error("Wrong single channel"); // [RL1]

    property p_ext_only;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (ctrl_q.ext && CONV_START_O) |-> $past(ext_sync_q[1], 1) == 1'b0 && ext_sync_q[1];
    endproperty
    a_ext_only: assert property (p_ext_only) else $error("Start not ext edge"); // [RL16]

    property p_dout;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (BUS_I.wr && hit(BUS_I, DAQC_OFS_DIO)) |=> DOUT_O == $past(BUS_I.wdata[15:0]);
    endproperty
    a_dout: assert property (p_dout) else $error("Outputs not updated"); // [RL11]

endmodule : daqc_top

// ===== daqc_conv_model.sv
// Converter stand-in: answers each start pulse taken while idle with one done pulse and a result.
// Assumes start is sampled on the rising core clock edge.
`timescale 1ns/100ps
module daqc_conv_model
(
    input  wire logic        clk_i,   // Core clock.
    input  wire logic        rst_n_i, // Async reset, active low.
    input  wire logic        start_i, // Start pulse.
    input  wire logic [7:0]  dly_i,   // Cycles until done.
    input  wire logic [11:0] val_i,   // Result to hand back.
    output logic             done_o,  // Done pulse.
    output logic [11:0]      data_o   // Result bus.
);
    logic [7:0] cnt_q;
    logic       busy_q;
    // Off the done cycle the bus shows the inverse, so a late sample is caught.
    assign data_o = done_o ? val_i : ~val_i;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q  <= 8'h00;
            busy_q <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= busy_q && (cnt_q == 8'h00);
            if (start_i && !busy_q)
            begin
                busy_q <= 1'b1;
                cnt_q  <= dly_i;
            end
            else if (busy_q && cnt_q == 8'h00)
                busy_q <= 1'b0;
            else if (busy_q)
                cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule : daqc_conv_model

// ===== testbench.sv
// Self-checking bench for the acquisition control block.
// Assumes the converter stand-in on the far side of the start/done pair.
`timescale 1ns/100ps
module testbench;
    import daqc_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    daqc_bus_t   bus = '0;
    logic [31:0] rdata;
    logic [31:0] trd = 32'h0;
    logic        tsel, twr, start, done, uni, irq_en, dma_en, st_seen, ts, tw;
    logic        pac = 1'b0, ext = 1'b0, full = 1'b0;
    logic [1:0]  tadr, ta;
    logic [15:0] din = 16'h0, dout;
    logic [3:0]  channel_select, rng;
    logic [11:0] cdat, cval = 12'h0;
    logic [7:0]  dly = 8'h14;
    int          error_cnt = 0;
    int          checks = 0;
    always #20 clk = ~clk;
    daqc_top dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .BUS_I(bus), .RDATA_O(rdata),
        .TMR_SEL_O(tsel), .TMR_ADDR_O(tadr), .TMR_CTRL_WR_O(twr), .TMR_RDATA_I(trd),
        .PACER_OUT_I(pac), .EXT_TRIG_I(ext), .DIN_I(din), .DOUT_O(dout), .MUX_SEL_O(channel_select),
        .RANGE_O(rng), .RANGE_UNI_O(uni), .CONV_START_O(start), .CONV_DONE_I(done),
        .CONV_DATA_I(cdat), .DMA_FULL_I(full), .IRQ_EN_O(irq_en), .DMA_EN_O(dma_en));
    daqc_conv_model conv (.clk_i(clk), .rst_n_i(rst_n), .start_i(start), .dly_i(dly),
        .val_i(cval), .done_o(done), .data_o(cdat));
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic final_report();
        if (error_cnt == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        bus <= '{sel: 1'b1, wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        q = rdata;
        st_seen = start;
        ts = tsel;
        ta = tadr;
        tw = twr;
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
    endtask : acc
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
    endtask : wr
    task automatic wait_hi(input logic pick, input int lim);
        int n;
        n = 0;
        while ((pick ? done : start) !== 1'b1 && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        if ((pick ? done : start) !== 1'b1)
        begin
            error_cnt++;
            final_report();
        end
        repeat (2) @(negedge clk);
    endtask : wait_hi
    function automatic logic [31:0] ctl(input logic [3:0] r, input logic [3:0] c,
                                        input logic s, input logic [3:0] m);
        return {19'h0, r, c, s, m};
    endfunction : ctl
    task automatic t_reset();
        logic [31:0] r;
        acc(1'b0, DAQC_OFS_CTLSTAT, 32'h0, r);
        chk("status", 32'(r[1:0]), 32'h0);
        chk("outs", 32'({channel_select, rng, irq_en, dma_en, dout}), 32'h0);
    endtask : t_reset
    task automatic t_ctrl();
        for (int c = 0; c < 9; c++)
        begin
            wr(DAQC_OFS_CTLSTAT, ctl(4'(c), 4'(c + 7), 1'b0, {2'b00, 2'(c)}));
            chk("range", 32'(rng), 32'(c));
            chk("unipolar", 32'(uni), 32'(c >= 4 && c <= 7));
            chk("mux", 32'(channel_select), 32'(c + 7));
            chk("xfer", 32'({irq_en, dma_en}), 32'(c % 4));
        end
    endtask : t_ctrl
    task automatic t_soft(input logic [3:0] ch, input logic [11:0] v);
        logic [31:0] r;
        cval <= v;
        dly <= 8'h14;
        wr(DAQC_OFS_CTLSTAT, ctl(4'h0, ch, 1'b0, 4'h0));
        wr(DAQC_OFS_SWTRIG, 32'hFFFF_FFFF);
        chk("start", 32'(st_seen), 32'h1);
        acc(1'b0, DAQC_OFS_CTLSTAT, 32'h0, r);
        chk("busy", 32'(r[0]), 32'h0);
        wait_hi(1'b1, 300);
        acc(1'b0, DAQC_OFS_CTLSTAT, 32'h0, r);
        chk("ready", 32'(r[0]), 32'h1);
        acc(1'b0, DAQC_OFS_ADDATA, 32'h0, r);
        chk("data", 32'(r[15:0]), 32'({v, ch}));
        acc(1'b0, DAQC_OFS_CTLSTAT, 32'h0, r);
        chk("ready_clr", 32'(r[0]), 32'h0);
    endtask : t_soft
    task automatic t_scan();
        logic [31:0] r;
        logic [3:0]  e [5] = '{4'h2, 4'h1, 4'h2, 4'h1, 4'h0};
        dly <= 8'h03;
        for (int i = 0; i < 6; i++)
        begin
            if (i == 0 || i == 2)
                wr(DAQC_OFS_CTLSTAT, ctl(4'h0, 4'h2, 1'b1, 4'h0));
            wr(DAQC_OFS_SWTRIG, 32'h0);
            wait_hi(1'b1, 300);
            acc(1'b0, DAQC_OFS_ADDATA, 32'h0, r);
            chk("scan_ch", 32'(r[3:0]), 32'((i < 5) ? e[i] : 4'h2));
        end
    endtask : t_scan
    task automatic t_ovr(input logic [3:0] m);
        logic [31:0] r;
        full <= 1'b1;
        wr(DAQC_OFS_CTLSTAT, ctl(4'h0, 4'h3, 1'b0, m));
        repeat (2)
        begin
            wr(DAQC_OFS_SWTRIG, 32'h0);
            wait_hi(1'b1, 300);
        end
        acc(1'b0, DAQC_OFS_CTLSTAT, 32'h0, r);
        chk("overrun", 32'(r[1]), 32'(m[0]));
        wr(DAQC_OFS_CTLSTAT, ctl(4'h0, 4'h3, 1'b0, 4'h0));
        acc(1'b0, DAQC_OFS_CTLSTAT, 32'h0, r);
        chk("ovr_clr", 32'(r[1]), 32'h0);
        acc(1'b0, DAQC_OFS_ADDATA, 32'h0, r);
        chk("ovr_data", 32'(r[3:0]), 32'h3);
        full <= 1'b0;
    endtask : t_ovr
    task automatic t_io();
        logic [31:0] r;
        @(posedge clk);
        din <= 16'hA5C3;
        trd <= 32'h0001_2345;
        wr(DAQC_OFS_DIO, 32'hFFFF_3C96);
        chk("dout", 32'(dout), 32'h3C96);
        acc(1'b0, DAQC_OFS_DIO, 32'h0, r);
        chk("din", r, 32'h0000_A5C3);
        for (int i = 0; i < 3; i++)
        begin
            acc(1'b0, 6'(4 * i), 32'h0, r);
            chk("tmr_rd", r, 32'h0001_2345);
            chk("tmr_sel", 32'({ts, ta}), 32'(4 + i));
        end
        wr(DAQC_OFS_TCTRL, 32'h36);
        chk("tmr_ctl", 32'(tw), 32'h1);
    endtask : t_io
    task automatic t_pin(input logic [3:0] m);
        logic [31:0] r;
        wr(DAQC_OFS_CTLSTAT, ctl(4'h0, 4'h4, 1'b0, m));
        @(posedge clk);
        ext <= m[3];
        pac <= !m[3];
        wait_hi(1'b0, 10);
        wait_hi(1'b1, 300);
        acc(1'b0, DAQC_OFS_ADDATA, 32'h0, r);
        chk("pin_ch", 32'(r[3:0]), 32'h4);
        wr(DAQC_OFS_SWTRIG, 32'h0);
        chk("sw_off", 32'(st_seen), 32'h0);
        @(posedge clk);
        ext <= 1'b0;
        pac <= 1'b0;
    endtask : t_pin
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_ctrl();
        t_soft(4'hF, 12'hA5C);
        t_scan();
        t_ovr(4'h0);
        t_ovr(4'h1);
        t_io();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_pin(4'h8);
        t_pin(4'h4);
        final_report();
    end
endmodule : testbench
